// *** inc/aab_pkg.sv ***
/*
  Constants and types for the accumulator ALU bit-ops datapath.
  Assumes every user writes aab_pkg::name and nothing is imported.
*/
// Summary of operation
// - Literal add into work; carry, digit carry, zero
// - Work plus file; carry, digit carry, zero
// - Destination bit: 0 to work, 1 file
// - Literal AND into work, zero flag only
// - Bit clear in file, flags untouched
// - Bit set in file, flags untouched
// - Tested bit zero: continue, flags untouched
// - Tested bit one: next becomes no-op
package aab_pkg;

  localparam int unsigned DATA_W      = 8;
  localparam int unsigned FILE_ADDR_W = 7;
  localparam int unsigned FILE_DEPTH  = 128;
  localparam int unsigned BIT_IDX_W   = 3;
  localparam int unsigned BUS_ADDR_W  = 8;

  // Status and exec register field positions
  localparam int unsigned STAT_CARRY_BIT = 0;
  localparam int unsigned STAT_DIGIT_BIT = 1;
  localparam int unsigned STAT_ZERO_BIT  = 2;
  localparam int unsigned EXEC_FLUSH_BIT = 0;

  // Reset values
  localparam logic [7:0] WORK_RESET  = 8'h00;
  localparam logic [7:0] FILE_RESET  = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic       FLAG_RESET  = 1'b0;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // Register bus map
  localparam logic [7:0] OFS_FILE_LAST = 8'h7f;
  localparam logic [7:0] OFS_WORK      = 8'h80;
  localparam logic [7:0] OFS_STATUS    = 8'h81;
  localparam logic [7:0] OFS_EXEC      = 8'h82;
  localparam logic [7:0] OFS_RETIRED   = 8'h83;

  // Destination select encodings
  localparam logic DEST_WORK = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  typedef enum logic [2:0] {
    aab_op_no_operation,
    aab_op_add_literal_to_work,
    aab_op_add_work_and_file,
    aab_op_and_literal_with_work,
    aab_op_bit_clear_file,
    aab_op_bit_set_file,
    aab_op_bit_test_skip_if_set
  } aab_op_t;

  typedef enum logic {
    aab_exec_run,
    aab_exec_flush
  } aab_exec_t;

endpackage

// *** inc/aab_file_if.sv ***
/*
  Carrier between the datapath and its file register store.
  Assumes one clock; reads are combinational, writes take the edge.
*/
`timescale 1ns/1ps
`default_nettype none
interface aab_file_if;
  logic       wr_en;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [6:0] op_addr;
  logic [7:0] op_data;
  logic [6:0] bus_addr;
  logic [7:0] bus_data;

  modport core (
    output wr_en,
    output wr_addr,
    output wr_data,
    output op_addr,
    output bus_addr,
    input  op_data,
    input  bus_data
  );

  modport store (
    input  wr_en,
    input  wr_addr,
    input  wr_data,
    input  op_addr,
    input  bus_addr,
    output op_data,
    output bus_data
  );
endinterface
`default_nettype wire

// *** src/aab_file_store.sv ***
/*
  The 128-location file register space, one write and two read ports.
  Assumes the core arbitrates so that one write arrives per cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module aab_file_store (
  input  wire logic core_clk,
  input  wire logic reset,
  aab_file_if.store fif
);

  logic [7:0] mem_ff [aab_pkg::FILE_DEPTH];

  // Two asynchronous read ports: datapath and bus
  assign fif.op_data  = mem_ff[fif.op_addr];
  assign fif.bus_data = mem_ff[fif.bus_addr];

  ////////////////////////////////////////////////////////////////////
  // One register per location, cleared by reset
  genvar gi;
  generate
    for (gi = 0; gi < aab_pkg::FILE_DEPTH; gi++) begin : g_loc
      logic [7:0] nxt_loc;
      // Write hits only the addressed location
      always_comb begin
        nxt_loc = mem_ff[gi];
        if (fif.wr_en && (fif.wr_addr == 7'(gi))) begin
          nxt_loc = fif.wr_data;
        end
      end
      always_ff @(posedge core_clk) begin
        if (reset) begin
          mem_ff[gi] <= aab_pkg::FILE_RESET;
        end else begin
          mem_ff[gi] <= nxt_loc;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// *** src/aab_core.sv ***
/*
  Accumulator ALU datapath: adds, literal AND, bit clear/set and
  bit test with skip, with the work register, status flags and a
  register port for software.
  Assumes instructions arrive one per instruction cycle from logic on
  core_clk, so no input synchroniser is needed.
  Limitation: a software file write that meets an instruction write is lost.
*/
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module aab_core (
  input  wire logic            core_clk,
  input  wire logic            reset,
  // Instruction issue
  input  wire logic            op_valid,
  input  wire aab_pkg::aab_op_t op_code,
  input  wire logic [7:0]      op_literal,
  input  wire logic [6:0]      op_file_addr,
  input  wire logic            op_dest_sel,
  input  wire logic [2:0]      op_bit_idx,
  output logic                 op_discarded,
  output logic                 op_done,
  output logic                 skip_taken,
  output logic                 skip_pending,
  // Datapath state
  output logic [7:0]           work_value,
  output logic                 carry_flag,
  output logic                 digit_carry_flag,
  output logic                 zero_flag,
  // Register port
  input  wire logic [7:0]      bus_addr,
  input  wire logic [7:0]      bus_wdata,
  input  wire logic            bus_wr,
  input  wire logic            bus_rd,
  output logic [7:0]           bus_rdata
);

  ////////////////////////////////////////////////////////////////////
  // State and next values

  aab_pkg::aab_exec_t exec_ff;
  aab_pkg::aab_exec_t nxt_exec;
  logic [7:0]         work_ff;
  logic [7:0]         nxt_work;
  logic               carry_ff;
  logic               nxt_carry;
  logic               digit_ff;
  logic               nxt_digit;
  logic               zero_ff;
  logic               nxt_zero;
  logic               done_ff;
  logic               nxt_done;
  logic               skip_ff;
  logic               nxt_skip;
  logic [7:0]         retired_ff;
  logic [7:0]         nxt_retired;
  logic [7:0]         rdata_ff;
  logic [7:0]         nxt_rdata;

  // Datapath helpers
  logic               op_live;
  logic [7:0]         file_val;
  logic [7:0]         bit_mask;
  logic [7:0]         add_b;
  logic [9:0]         add_res;
  logic [7:0]         and_res;
  logic               op_wr_en;
  logic [7:0]         op_wr_data;
  logic               bus_file_hit;
  logic [7:0]         status_word;
  logic [7:0]         exec_word;

  aab_file_if fif ();

  aab_file_store u_store (
    .core_clk (core_clk),
    .reset    (reset),
    .fif      (fif)
  );

  ////////////////////////////////////////////////////////////////////
  // Eight-bit add with carry out of bit 7 and bit 3
  // Nibble sum kept apart, since the full sum hides the bit 3 carry

  function automatic logic [9:0] aab_add(input logic [7:0] a,
                                        input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] n;
    s = {1'b0, a} + {1'b0, b};
    n = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    return {n[4], s};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Operand fetch and shared adder

  // A discarded slot never reaches the datapath
  assign op_live      = op_valid && (exec_ff == aab_pkg::aab_exec_run);
  assign op_discarded = op_valid && (exec_ff == aab_pkg::aab_exec_flush);
  assign fif.op_addr  = op_file_addr;
  assign file_val     = fif.op_data;
  assign bit_mask     = 8'h01 << op_bit_idx;

  // One adder serves both adds; the literal form ignores the file
  always_comb begin
    add_b = op_literal;
    if (op_code == aab_pkg::aab_op_add_work_and_file) begin
      add_b = file_val;
    end
  end

  assign add_res = aab_add(work_ff, add_b);

  // AND result shared by the work write and the zero test
  assign and_res = work_ff & op_literal;

  ////////////////////////////////////////////////////////////////////
  // Instruction execution and software writes

  // Software writes first; an instruction in the same cycle overrides
  // Flags that an instruction leaves alone keep the software value
  always_comb begin
    nxt_exec    = exec_ff;
    nxt_work    = work_ff;
    nxt_carry   = carry_ff;
    nxt_digit   = digit_ff;
    nxt_zero    = zero_ff;
    nxt_done    = 1'b0;
    nxt_skip    = 1'b0;
    nxt_retired = retired_ff;
    op_wr_en    = 1'b0;
    op_wr_data  = file_val;

    if (bus_wr && (bus_addr == aab_pkg::OFS_WORK)) begin
      nxt_work = bus_wdata;
    end
    if (bus_wr && (bus_addr == aab_pkg::OFS_STATUS)) begin
      nxt_carry = bus_wdata[aab_pkg::STAT_CARRY_BIT];
      nxt_digit = bus_wdata[aab_pkg::STAT_DIGIT_BIT];
      nxt_zero  = bus_wdata[aab_pkg::STAT_ZERO_BIT];
    end

    if (op_valid) begin
      nxt_done    = 1'b1;
      nxt_retired = retired_ff + 8'h01;
      unique case (exec_ff)
        aab_pkg::aab_exec_flush: begin
          // Slot spent as a no-operation, two cycles in all
          nxt_exec = aab_pkg::aab_exec_run;
        end
        aab_pkg::aab_exec_run: begin
          case (op_code)
            aab_pkg::aab_op_add_literal_to_work: begin
              nxt_work  = add_res[7:0];
              nxt_carry = add_res[8];
              nxt_digit = add_res[9];
              nxt_zero  = (add_res[7:0] == 8'h00);
            end
            aab_pkg::aab_op_add_work_and_file: begin
              nxt_carry = add_res[8];
              nxt_digit = add_res[9];
              nxt_zero  = (add_res[7:0] == 8'h00);
              if (op_dest_sel == aab_pkg::DEST_FILE) begin
                op_wr_en   = 1'b1;
                op_wr_data = add_res[7:0];
              end else begin
                nxt_work = add_res[7:0];
              end
            end
            aab_pkg::aab_op_and_literal_with_work: begin
              // Carry and digit carry keep their values
              nxt_work = and_res;
              nxt_zero = (and_res == 8'h00);
            end
            aab_pkg::aab_op_bit_clear_file: begin
              op_wr_en   = 1'b1;
              op_wr_data = file_val & ~bit_mask;
            end
            aab_pkg::aab_op_bit_set_file: begin
              op_wr_en   = 1'b1;
              op_wr_data = file_val | bit_mask;
            end
            aab_pkg::aab_op_bit_test_skip_if_set: begin
              // Bit clear: fall through, nothing changes
              if ((file_val & bit_mask) != 8'h00) begin
                nxt_exec = aab_pkg::aab_exec_flush;
                nxt_skip = 1'b1;
              end else begin
                nxt_exec = aab_pkg::aab_exec_run;
              end
            end
            default: begin
              // No-operation and the unused code do nothing
              nxt_exec = aab_pkg::aab_exec_run;
            end
          endcase
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // File write port arbitration

  // Instruction writes win; a colliding software write is dropped
  // No flag records the loss, so software keeps off cycles with any instruction file write
  assign bus_file_hit = bus_addr <= aab_pkg::OFS_FILE_LAST;

  always_comb begin
    fif.wr_en   = 1'b0;
    fif.wr_addr = op_file_addr;
    fif.wr_data = op_wr_data;
    if (op_live && op_wr_en) begin
      fif.wr_en = 1'b1;
    end else if (bus_wr && bus_file_hit) begin
      fif.wr_en   = 1'b1;
      fif.wr_addr = bus_addr[6:0];
      fif.wr_data = bus_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read side of the register port

  assign fif.bus_addr = bus_addr[6:0];

  // Assemble readable words; unused bits read as zero
  always_comb begin
    status_word = 8'h00;
    status_word[aab_pkg::STAT_CARRY_BIT] = carry_ff;
    status_word[aab_pkg::STAT_DIGIT_BIT] = digit_ff;
    status_word[aab_pkg::STAT_ZERO_BIT]  = zero_ff;
    exec_word = 8'h00;
    exec_word[aab_pkg::EXEC_FLUSH_BIT] =
      (exec_ff == aab_pkg::aab_exec_flush);
  end

  // Data stands one cycle after the strobe, zero elsewhere
  always_comb begin
    nxt_rdata = 8'h00;
    if (bus_rd) begin
      if (bus_file_hit) begin
        nxt_rdata = fif.bus_data;
      end else if (bus_addr == aab_pkg::OFS_WORK) begin
        nxt_rdata = work_ff;
      end else if (bus_addr == aab_pkg::OFS_STATUS) begin
        nxt_rdata = status_word;
      end else if (bus_addr == aab_pkg::OFS_EXEC) begin
        nxt_rdata = exec_word;
      end else if (bus_addr == aab_pkg::OFS_RETIRED) begin
        nxt_rdata = retired_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registers

  // Datapath state; reset also drops a pending skip
  always_ff @(posedge core_clk) begin
    if (reset) begin
      exec_ff    <= aab_pkg::aab_exec_run;
      work_ff    <= aab_pkg::WORK_RESET;
      carry_ff   <= aab_pkg::FLAG_RESET;
      digit_ff   <= aab_pkg::FLAG_RESET;
      zero_ff    <= aab_pkg::FLAG_RESET;
      done_ff    <= aab_pkg::FLAG_RESET;
      skip_ff    <= aab_pkg::FLAG_RESET;
      retired_ff <= aab_pkg::COUNT_RESET;
    end else begin
      exec_ff    <= nxt_exec;
      work_ff    <= nxt_work;
      carry_ff   <= nxt_carry;
      digit_ff   <= nxt_digit;
      zero_ff    <= nxt_zero;
      done_ff    <= nxt_done;
      skip_ff    <= nxt_skip;
      retired_ff <= nxt_retired;
    end
  end

  // Read data register; its own group so the port idles at zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_ff <= aab_pkg::RDATA_RESET;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  // Pending skip holds until the next slot arrives, however late
  assign skip_pending     = (exec_ff == aab_pkg::aab_exec_flush);
  assign op_done          = done_ff;
  assign skip_taken       = skip_ff;
  assign work_value       = work_ff;
  assign carry_flag       = carry_ff;
  // Flags leave straight from flops, never from the adder
  assign digit_carry_flag = digit_ff;
  assign zero_flag        = zero_ff;
  assign bus_rdata        = rdata_ff;

endmodule
`default_nettype wire

// *** test/aab_core_assertions.sv ***
/*
  Checker for the accumulator ALU bit-ops core, bound to its ports.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module aab_core_assertions (
  input wire logic             core_clk,
  input wire logic             reset,
  input wire logic             op_valid,
  input wire aab_pkg::aab_op_t op_code,
  input wire logic [7:0]       op_literal,
  input wire logic             op_discarded,
  input wire logic             op_done,
  input wire logic             skip_taken,
  input wire logic             skip_pending,
  input wire logic [7:0]       work_value,
  input wire logic             carry_flag,
  input wire logic             digit_carry_flag,
  input wire logic             zero_flag,
  input wire logic             bus_wr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  logic       live;
  logic [8:0] sum_ff;
  logic [4:0] nib_ff;
  logic [7:0] and_ff;

  // Executed op with no software write racing it
  assign live = op_valid && !skip_pending && !bus_wr;

  // Expected literal results, one cycle behind their operands
  always_ff @(posedge core_clk) begin
    sum_ff <= {1'b0, work_value} + {1'b0, op_literal};
    nib_ff <= {1'b0, work_value[3:0]} + {1'b0, op_literal[3:0]};
    and_ff <= work_value & op_literal;
  end

  a_done_after_op: assert property (op_valid |=> op_done)
    else $error("op_done missing after an op");
  a_no_stray_done: assert property (!op_valid |=> !op_done && !skip_taken)
    else $error("op_done or skip_taken without an op");
  a_discard_pending: assert property (op_discarded == (op_valid && skip_pending))
    else $error("op_discarded disagrees with pending skip");
  a_pending_holds: assert property (skip_pending && !op_valid |=> skip_pending)
    else $error("pending skip lost before the next op");
  a_pending_consumed: assert property (
    skip_pending && op_valid |=> !skip_pending && !skip_taken)
    else $error("pending skip not consumed by one op");
  a_discard_keeps: assert property (op_discarded && !bus_wr |=>
    $stable(work_value) && $stable({carry_flag, digit_carry_flag, zero_flag}))
    else $error("discarded op changed state");
  a_add_literal: assert property (
    live && op_code == aab_pkg::aab_op_add_literal_to_work |=>
    {carry_flag, work_value} == sum_ff && digit_carry_flag == nib_ff[4]
    && zero_flag == (work_value == 8'h00))
    else $error("literal add result or flags wrong");
  a_and_literal: assert property (
    live && op_code == aab_pkg::aab_op_and_literal_with_work |=>
    work_value == and_ff && zero_flag == (work_value == 8'h00)
    && $stable(carry_flag) && $stable(digit_carry_flag))
    else $error("literal and result or flags wrong");
  a_bit_ops_flags: assert property (
    live && (op_code == aab_pkg::aab_op_bit_clear_file
    || op_code == aab_pkg::aab_op_bit_set_file || op_code == aab_pkg::aab_op_bit_test_skip_if_set)
    |=> $stable({carry_flag, digit_carry_flag, zero_flag}) && $stable(work_value))
    else $error("bit op touched flags or work");
endmodule

bind aab_core aab_core_assertions aab_core_assertions_inst (
  .core_clk(core_clk), .reset(reset), .op_valid(op_valid), .op_code(op_code),
  .op_literal(op_literal), .op_discarded(op_discarded), .op_done(op_done),
  .skip_taken(skip_taken), .skip_pending(skip_pending), .work_value(work_value),
  .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag),
  .bus_wr(bus_wr)
);
`default_nettype wire

// *** test/testbench.sv ***
/*
  Self-checking bench for aab_core: each scenario a task of its own.
  Assumes the checker is bound in and the package is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic             core_clk;
  logic             reset;
  logic             op_valid;
  aab_pkg::aab_op_t op_code;
  logic [7:0]       op_literal;
  logic [6:0]       op_file_addr;
  logic             op_dest_sel;
  logic [2:0]       op_bit_idx;
  logic             op_discarded;
  logic             op_done;
  logic             skip_taken;
  logic             skip_pending;
  logic [7:0]       work_value;
  logic             carry_flag;
  logic             digit_carry_flag;
  logic             zero_flag;
  logic [7:0]       bus_addr;
  logic [7:0]       bus_wdata;
  logic             bus_wr;
  logic             bus_rd;
  logic [7:0]       bus_rdata;
  logic [7:0]       flg;
  int               n_fail;
  int               num_checks;

  aab_core aab_core_inst (
    .core_clk(core_clk), .reset(reset), .op_valid(op_valid), .op_code(op_code),
    .op_literal(op_literal), .op_file_addr(op_file_addr), .op_dest_sel(op_dest_sel),
    .op_bit_idx(op_bit_idx), .op_discarded(op_discarded), .op_done(op_done),
    .skip_taken(skip_taken), .skip_pending(skip_pending), .work_value(work_value),
    .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata)
  );

  // Flags packed as in the status register
  assign flg = {5'h00, zero_flag, digit_carry_flag, carry_flag};

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Presents one op; valid stays up so ops can run back to back
  task automatic go(input aab_pkg::aab_op_t c, input logic [7:0] k, input logic [6:0] f,
                    input logic d, input logic [2:0] b);
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_literal <= k;
    op_file_addr <= f;
    op_dest_sel <= d;
    op_bit_idx <= b;
  endtask

  task automatic stop;
    @(posedge core_clk);
    op_valid <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge core_clk);
    bus_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    #1;
    chk(bus_rdata, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_add_literal;
    wr(8'h80, 8'h8f);
    go(aab_pkg::aab_op_add_literal_to_work, 8'h71, 7'h00, 1'b0, 3'h0);
    stop;
    chk(work_value, 8'h00);
    chk(flg, 8'h07);
    go(aab_pkg::aab_op_add_literal_to_work, 8'hff, 7'h00, 1'b0, 3'h0);
    stop;
    chk(work_value, 8'hff);
    chk(flg, 8'h00);
    $display("test add_literal end");
  endtask

  // Top file address, both destinations
  task automatic t_add_file;
    wr(8'h7f, 8'h28);
    wr(8'h80, 8'h19);
    go(aab_pkg::aab_op_add_work_and_file, 8'h00, 7'h7f, aab_pkg::DEST_FILE, 3'h0);
    stop;
    rd(8'h7f, 8'h41);
    chk(work_value, 8'h19);
    chk(flg, 8'h02);
    go(aab_pkg::aab_op_add_work_and_file, 8'h00, 7'h7f, aab_pkg::DEST_WORK, 3'h0);
    stop;
    chk(work_value, 8'h5a);
    rd(8'h7f, 8'h41);
    chk(flg, 8'h00);
    $display("test add_file end");
  endtask

  // Carry and digit carry preset so their survival shows
  task automatic t_and_literal;
    wr(8'h81, 8'h03);
    wr(8'h80, 8'hf0);
    go(aab_pkg::aab_op_and_literal_with_work, 8'h0f, 7'h00, 1'b0, 3'h0);
    stop;
    chk(work_value, 8'h00);
    chk(flg, 8'h07);
    wr(8'h80, 8'hff);
    go(aab_pkg::aab_op_and_literal_with_work, 8'h3c, 7'h00, 1'b0, 3'h0);
    stop;
    chk(work_value, 8'h3c);
    chk(flg, 8'h03);
    go(aab_pkg::aab_op_no_operation, 8'hff, 7'h00, aab_pkg::DEST_FILE, 3'h0);
    stop;
    chk(work_value, 8'h3c);
    chk(flg, 8'h03);
    rd(8'h00, aab_pkg::FILE_RESET);
    $display("test and_literal end");
  endtask

  task automatic t_bits;
    logic [7:0] e;
    e = 8'h00;
    wr(8'h81, 8'h05);
    for (int i = 0; i < 8; i++) begin
      go(aab_pkg::aab_op_bit_set_file, 8'h00, 7'h00, 1'b0, 3'(i));
      stop;
      e = e | (8'h01 << i);
      rd(8'h00, e);
    end
    chk(flg, 8'h05);
    for (int i = 0; i < 8; i++) begin
      go(aab_pkg::aab_op_bit_clear_file, 8'h00, 7'h00, 1'b0, 3'(i));
      stop;
      e = e & ~(8'h01 << i);
      rd(8'h00, e);
    end
    chk(flg, 8'h05);
    $display("test bits end");
  endtask

  // Taken skip back to back, untaken skip, taken skip with a gap
  task automatic t_skip;
    wr(8'h03, 8'h04);
    wr(8'h80, 8'h10);
    go(aab_pkg::aab_op_bit_test_skip_if_set, 8'h00, 7'h03, 1'b0, 3'h2);
    go(aab_pkg::aab_op_add_literal_to_work, 8'h01, 7'h00, 1'b0, 3'h0);
    #1;
    chk({5'h00, op_done, skip_taken, op_discarded}, 8'h07);
    stop;
    chk(work_value, 8'h10);
    chk({7'h00, skip_pending}, 8'h00);
    go(aab_pkg::aab_op_bit_test_skip_if_set, 8'h00, 7'h03, 1'b0, 3'h1);
    go(aab_pkg::aab_op_add_literal_to_work, 8'h01, 7'h00, 1'b0, 3'h0);
    #1;
    chk({5'h00, op_done, skip_taken, op_discarded}, 8'h04);
    stop;
    chk(work_value, 8'h11);
    go(aab_pkg::aab_op_bit_test_skip_if_set, 8'h00, 7'h03, 1'b0, 3'h2);
    stop;
    rd(8'h82, 8'h01);
    go(aab_pkg::aab_op_add_literal_to_work, 8'h01, 7'h00, 1'b0, 3'h0);
    stop;
    chk(work_value, 8'h11);
    rd(aab_pkg::OFS_RETIRED, 8'h1d);
    $display("test skip end");
  endtask

  // Mid-run reset clears work, flags, file space and the op count
  task automatic t_reset;
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    #1;
    chk(work_value, aab_pkg::WORK_RESET);
    chk(flg, 8'h00);
    rd(8'h7f, aab_pkg::FILE_RESET);
    rd(aab_pkg::OFS_RETIRED, aab_pkg::COUNT_RESET);
    $display("test reset end");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    n_fail = 0;
    num_checks = 0;
    reset = 1'b1;
    op_valid = 1'b0;
    op_code = aab_pkg::aab_op_no_operation;
    op_literal = 8'h00;
    op_file_addr = 7'h00;
    op_dest_sel = 1'b0;
    op_bit_idx = 3'h0;
    bus_addr = 8'h00;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    #1;
    chk(flg, 8'h00);
    t_add_literal;
    t_add_file;
    t_and_literal;
    t_bits;
    t_skip;
    t_reset;
    print_verdict;
  end

  // Hang guard, well past the whole sequence
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    print_verdict;
  end
endmodule
`default_nettype wire
